// ---- rtl/pevirq_pkg.sv ----
// constants for the interrupt register set of one pattern evaluation channel
// assumes a plain 32-bit register port with byte addresses, one word per register
package pevirq_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_FLAGS = 8'h00;
    localparam logic [7:0] OFF_IRQ_EN = 8'h04;
    localparam logic [7:0] OFF_FORCE = 8'h08;
    localparam logic [7:0] OFF_MODE = 8'h0C;
    localparam logic [7:0] OFF_ERR_EN = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;

    // event field: five bits, lowest at 27, highest at 31
    localparam int EV_LSB = 27;
    localparam int EV_W = 5;
    localparam int BIT_NEW_PATTERN = 31;
    localparam int BIT_DIR_CHANGE = 30;
    localparam int BIT_PAT_ERROR = 29;
    localparam int BIT_BOUNCE = 28;
    localparam int BIT_REV_MATCH = 27;

    // index of each event inside the five-bit field
    localparam int IDX_NEW_PATTERN = BIT_NEW_PATTERN - EV_LSB;
    localparam int IDX_DIR_CHANGE = BIT_DIR_CHANGE - EV_LSB;
    localparam int IDX_PAT_ERROR = BIT_PAT_ERROR - EV_LSB;
    localparam int IDX_BOUNCE = BIT_BOUNCE - EV_LSB;
    localparam int IDX_REV_MATCH = BIT_REV_MATCH - EV_LSB;

    // signalling style field
    localparam int MODE_LSB = 30;
    localparam int MODE_W = 2;

    // control register: force protection
    localparam int CTRL_PROTECT_BIT = 0;

    // reset values
    localparam logic [31:0] RST_IRQ_REG = 32'h0000_0000;
    localparam logic [4:0] RST_EV = 5'h00;
    localparam logic RST_PROTECT = 1'h1;
    localparam logic RST_DIR = 1'h0;

    typedef enum logic [1:0] {
        MODE_LEVEL = 2'h0,
        MODE_PULSE = 2'h1,
        MODE_PULSE_NOTIFY = 2'h2,
        MODE_SINGLE_PULSE = 2'h3
    } pevirq_mode_type;

endpackage : pevirq_pkg

// ---- rtl/pevirq_regs.sv ----
// interrupt flags, enables, force triggers and style select of one evaluation channel
// assumes event inputs are single-cycle pulses from logic on the same clock,
// and a register master that never issues read and write together
// Operation
// - new pattern sets event bit 31, held until software clears it except in pulse style
// - new pattern that changes rotation direction sets event bit 30
// - invalid or wrong input pattern sets event bit 29
// - bouncing input detected sets event bit 28
// - revolution count equal to compare value sets event bit 27
// - writing one clears a flag; writing zero leaves it
// - reading the flag register changes no flag
// - per-event enable at same position gates the interrupt output
// - writing one to a force bit sets its flag like the event
// - writing zero to a force bit forces nothing
// - force bits clear themselves once the forced event is delivered
// - force writes are ignored while force protection is set
// - style field selects level, pulse, pulse-notify or single-pulse
// - unused bits read zero; software writes zeros there
// - all interrupt registers reset to zero except the control register, whose force protection bit resets to one
// - second per-event enable routes the event to the error output
// - match flag only from input-driven counter steps or a force write, never from other writes
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module pevirq_regs
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic new_pattern_i,
    input wire logic rotation_direction_i,
    input wire logic pattern_error_i,
    input wire logic bounce_i,
    input wire logic rev_count_step_i,
    input wire logic rev_count_equal_i,
    output logic irq_o,
    output logic err_irq_o
);

    logic [4:0] flags_q;
    logic [4:0] flags_d;
    logic [4:0] en_q;
    logic [4:0] err_en_q;
    logic [4:0] trig_q;
    logic [4:0] trig_d;
    pevirq_pkg::pevirq_mode_type mode_q;
    logic protect_q;
    logic dir_prev_q;
    logic [31:0] rdata_q;
    logic irq_q;
    logic irq_d;
    logic err_irq_q;

    // address decode
    wire logic sel_flags = (addr_i == pevirq_pkg::OFF_FLAGS);
    wire logic sel_en = (addr_i == pevirq_pkg::OFF_IRQ_EN);
    wire logic sel_force = (addr_i == pevirq_pkg::OFF_FORCE);
    wire logic sel_mode = (addr_i == pevirq_pkg::OFF_MODE);
    wire logic sel_err_en = (addr_i == pevirq_pkg::OFF_ERR_EN);
    wire logic sel_ctrl = (addr_i == pevirq_pkg::OFF_CTRL);

    wire logic wr_flags = wr_i & sel_flags;
    wire logic wr_en = wr_i & sel_en;
    wire logic wr_force = wr_i & sel_force;
    wire logic wr_mode = wr_i & sel_mode;
    wire logic wr_err_en = wr_i & sel_err_en;
    wire logic wr_ctrl = wr_i & sel_ctrl;

    wire logic [4:0] wr_ev = wdata_i[pevirq_pkg::EV_LSB +: pevirq_pkg::EV_W];

    wire logic dir_change = new_pattern_i & (rotation_direction_i != dir_prev_q);

    wire logic rev_match = rev_count_step_i & rev_count_equal_i;

    wire logic [4:0] hw_ev = {new_pattern_i, dir_change, pattern_error_i, bounce_i, rev_match};

    wire logic [4:0] set_ev = hw_ev | trig_q;

    wire logic [4:0] clr_ev = wr_flags ? wr_ev : 5'h00;

    wire logic pulse_mode = (mode_q == pevirq_pkg::MODE_PULSE);
    wire logic [4:0] flags_en = flags_q & en_q;
    wire logic [4:0] set_en = set_ev & en_q;

    // per-event sticky flags
    // set beats clear so an event in the clearing cycle survives; pulse style keeps no history
    for (genvar i = 0; i < pevirq_pkg::EV_W; i++)
    begin : g_flag
        assign flags_d[i] = pulse_mode ? set_ev[i] : (set_ev[i] | (flags_q[i] & ~clr_ev[i]));
    end

    wire logic force_ok = wr_force & ~protect_q;

    assign trig_d = force_ok ? wr_ev : pevirq_pkg::RST_EV;

    always_comb
    begin
        case (mode_q)
            pevirq_pkg::MODE_LEVEL: irq_d = |flags_en;
            pevirq_pkg::MODE_PULSE: irq_d = |set_en;
            pevirq_pkg::MODE_PULSE_NOTIFY: irq_d = |set_en;
            pevirq_pkg::MODE_SINGLE_PULSE: irq_d = (|set_en) & ~(|flags_en);
            default: irq_d = 1'h0;
        endcase
    end

    // reserved bits read zero
    // unmapped addresses read zero as well
    wire logic [31:0] rd_mux =
        sel_flags ? {flags_q, 27'h000_0000} :
        sel_en ? {en_q, 27'h000_0000} :
        sel_force ? {trig_q, 27'h000_0000} :
        sel_mode ? {mode_q, 30'h0000_0000} :
        sel_err_en ? {err_en_q, 27'h000_0000} :
        sel_ctrl ? {31'h0000_0000, protect_q} :
        pevirq_pkg::RST_IRQ_REG;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            flags_q <= pevirq_pkg::RST_EV;
            trig_q <= pevirq_pkg::RST_EV;
            dir_prev_q <= pevirq_pkg::RST_DIR;
        end
        else
        begin
            flags_q <= flags_d;
            trig_q <= trig_d;
            if (new_pattern_i)
            begin
                dir_prev_q <= rotation_direction_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            en_q <= pevirq_pkg::RST_EV;
            err_en_q <= pevirq_pkg::RST_EV;
            mode_q <= pevirq_pkg::MODE_LEVEL;
            protect_q <= pevirq_pkg::RST_PROTECT;
        end
        else
        begin
            if (wr_en)
            begin
                en_q <= wr_ev;
            end
            if (wr_err_en)
            begin
                err_en_q <= wr_ev;
            end
            if (wr_mode)
            begin
                mode_q <= pevirq_pkg::pevirq_mode_type'(
                    wdata_i[pevirq_pkg::MODE_LSB +: pevirq_pkg::MODE_W]);
            end
            if (wr_ctrl)
            begin
                protect_q <= wdata_i[pevirq_pkg::CTRL_PROTECT_BIT];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_q <= pevirq_pkg::RST_IRQ_REG;
            irq_q <= 1'h0;
            err_irq_q <= 1'h0;
        end
        else
        begin
            rdata_q <= rd_i ? rd_mux : pevirq_pkg::RST_IRQ_REG;
            irq_q <= irq_d;
            err_irq_q <= |(flags_q & err_en_q);
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
    assign err_irq_o = err_irq_q;

    // ------------------------------------------------------------------
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    property p_new_pattern_sets;
        new_pattern_i && !pulse_mode |=> flags_q[pevirq_pkg::IDX_NEW_PATTERN];
    endproperty
    a_new_pattern_sets: assert property (p_new_pattern_sets)
        else $error("new pattern did not set its flag");

    property p_dir_change_sets;
        new_pattern_i && (rotation_direction_i != dir_prev_q) && !pulse_mode
            |=> flags_q[pevirq_pkg::IDX_DIR_CHANGE];
    endproperty
    a_dir_change_sets: assert property (p_dir_change_sets)
        else $error("direction change did not set its flag");

    property p_pat_error_sets;
        pattern_error_i && !pulse_mode |=> flags_q[pevirq_pkg::IDX_PAT_ERROR];
    endproperty
    a_pat_error_sets: assert property (p_pat_error_sets)
        else $error("pattern error did not set its flag");

    property p_bounce_sets;
        bounce_i && !pulse_mode |=> flags_q[pevirq_pkg::IDX_BOUNCE];
    endproperty
    a_bounce_sets: assert property (p_bounce_sets)
        else $error("bounce did not set its flag");

    property p_match_sets;
        rev_count_step_i && rev_count_equal_i && !pulse_mode
            |=> flags_q[pevirq_pkg::IDX_REV_MATCH];
    endproperty
    a_match_sets: assert property (p_match_sets)
        else $error("revolution match did not set its flag");

    property p_match_cause;
        $rose(flags_q[pevirq_pkg::IDX_REV_MATCH])
            |-> $past(rev_match)
                || $past(trig_q[pevirq_pkg::IDX_REV_MATCH]);
    endproperty
    a_match_cause: assert property (p_match_cause)
        else $error("match flag rose without a counter step or force");

    property p_clear_one;
        wr_flags && wr_ev[pevirq_pkg::IDX_NEW_PATTERN]
            && !set_ev[pevirq_pkg::IDX_NEW_PATTERN]
            |=> !flags_q[pevirq_pkg::IDX_NEW_PATTERN];
    endproperty
    a_clear_one: assert property (p_clear_one)
        else $error("write one did not clear the flag");

    property p_read_keeps;
        rd_i && !pulse_mode |=> flags_q == ($past(flags_q) | $past(set_ev));
    endproperty
    a_read_keeps: assert property (p_read_keeps)
        else $error("read altered the flags");

    property p_level_out;
        mode_q == pevirq_pkg::MODE_LEVEL && !wr_mode |=> irq_o == |$past(flags_en);
    endproperty
    a_level_out: assert property (p_level_out)
        else $error("level output differs from flag and enable");

    property p_masked_quiet;
        (en_q == 5'h00) && (mode_q != pevirq_pkg::MODE_PULSE) |=> !irq_o;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("interrupt raised with all enables off");

    property p_force_sets;
        force_ok && wr_ev[pevirq_pkg::IDX_PAT_ERROR] && !pulse_mode && !wr_mode
            |-> ##2 flags_q[pevirq_pkg::IDX_PAT_ERROR];
    endproperty
    a_force_sets: assert property (p_force_sets)
        else $error("force did not set the flag");

    property p_force_zero;
        wr_force && (wr_ev == 5'h00) |=> trig_q == 5'h00;
    endproperty
    a_force_zero: assert property (p_force_zero)
        else $error("zero force write left a trigger");

    property p_trig_self_clear;
        (trig_q != 5'h00) && !wr_force |=> trig_q == 5'h00;
    endproperty
    a_trig_self_clear: assert property (p_trig_self_clear)
        else $error("trigger did not clear itself");

    property p_protect;
        wr_force && protect_q |=> trig_q == 5'h00;
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected force write was taken");

    property p_single_pulse;
        mode_q == pevirq_pkg::MODE_SINGLE_PULSE && !wr_mode && (|flags_en) |=> !irq_o;
    endproperty
    a_single_pulse: assert property (p_single_pulse)
        else $error("single pulse repeated while a flag is pending");

    property p_reserved_zero;
        rd_i && !sel_ctrl |=> rdata_o[26:0] == 27'h000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_err_out;
        (|(flags_q & err_en_q)) |=> err_irq_o;
    endproperty
    a_err_out: assert property (p_err_out)
        else $error("error output missed an enabled flag");

    property p_err_quiet;
        (err_en_q == 5'h00) |=> !err_irq_o;
    endproperty
    a_err_quiet: assert property (p_err_quiet)
        else $error("error output raised with all error enables off");

    property p_pulse_out;
        mode_q == pevirq_pkg::MODE_PULSE |=> irq_o == |$past(set_en);
    endproperty
    a_pulse_out: assert property (p_pulse_out)
        else $error("pulse style output differs from the enabled events");

    property p_notify_out;
        mode_q == pevirq_pkg::MODE_PULSE_NOTIFY |=> irq_o == |$past(set_en);
    endproperty
    a_notify_out: assert property (p_notify_out)
        else $error("pulse-notify output differs from the enabled events");

    // pulse style keeps no history, so a flag lives exactly one cycle
    property p_pulse_no_hold;
        pulse_mode |=> flags_q == $past(set_ev);
    endproperty
    a_pulse_no_hold: assert property (p_pulse_no_hold)
        else $error("pulse style kept a flag past its event");

    property p_clear_keeps;
        wr_flags && !pulse_mode
            |=> flags_q == (($past(flags_q) & ~$past(wr_ev)) | $past(set_ev));
    endproperty
    a_clear_keeps: assert property (p_clear_keeps)
        else $error("flag write did not clear exactly the ones written");

    property p_trig_taken;
        force_ok |=> trig_q == $past(wr_ev);
    endproperty
    a_trig_taken: assert property (p_trig_taken)
        else $error("unprotected force write was not taken");

    property p_dir_tracks;
        new_pattern_i |=> dir_prev_q == $past(rotation_direction_i);
    endproperty
    a_dir_tracks: assert property (p_dir_tracks)
        else $error("stored direction not updated on a new pattern");

    property p_unmapped_zero;
        rd_i && !(sel_flags || sel_en || sel_force || sel_mode || sel_err_en || sel_ctrl)
            |=> rdata_o == pevirq_pkg::RST_IRQ_REG;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped address read nonzero");

    c_force_path: cover property (force_ok ##1 (trig_q != 5'h00) ##1 irq_o);
    c_single_pulse: cover property (mode_q == pevirq_pkg::MODE_SINGLE_PULSE && irq_o);
    c_dir_change: cover property (dir_change ##2 irq_o);
    c_rev_match: cover property (rev_match ##1 flags_q[pevirq_pkg::IDX_REV_MATCH]);
    c_notify: cover property (mode_q == pevirq_pkg::MODE_PULSE_NOTIFY && irq_o);

endmodule : pevirq_regs

// ---- testbench/pevirq_src.sv ----
// event source model standing in for the pattern decoder and revolution counter
// assumes fire() is entered just after a rising clock edge
`timescale 1ns/1ps

module pevirq_src
(
    input wire logic clk_i,
    output logic new_pattern_o,
    output logic rotation_direction_o,
    output logic pattern_error_o,
    output logic bounce_o,
    output logic rev_count_step_o,
    output logic rev_count_equal_o
);
    initial
    begin
        {new_pattern_o, rotation_direction_o, pattern_error_o} = 3'h0;
        {bounce_o, rev_count_step_o, rev_count_equal_o} = 3'h0;
    end

    // v = {new, dir, error, bounce, step, equal}; direction stays as a level
    task automatic fire(input logic [5:0] v);
        {new_pattern_o, rotation_direction_o, pattern_error_o} <= v[5:3];
        {bounce_o, rev_count_step_o, rev_count_equal_o} <= v[2:0];
        @(posedge clk_i);
        {new_pattern_o, pattern_error_o, bounce_o, rev_count_step_o} <= 4'h0;
        // counter moves on, so equality is not held past the step
        rev_count_equal_o <= 1'b0;
    endtask : fire
endmodule : pevirq_src

// ---- testbench/tb_pevirq_regs.sv ----
// self-checking bench for the channel interrupt register set
// assumes the event source model pevirq_src and one 50 MHz clock
`timescale 1ns/1ps

module tb_pevirq_regs;
    logic clk_i;
    logic resetn_i;
    logic [7:0] addr_i;
    logic [31:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [31:0] rdata_o;
    logic np, dir, perr, bnc, step, eq;
    logic irq_o;
    logic err_irq_o;
    logic [5:0] ev_v [8];
    logic [31:0] ev_e [8];
    int err_total;
    int checks_done;
    int cycles;
    int i;
    localparam logic [7:0] FL = pevirq_pkg::OFF_FLAGS;
    localparam logic [7:0] EN = pevirq_pkg::OFF_IRQ_EN;
    localparam logic [7:0] EE = pevirq_pkg::OFF_ERR_EN;
    localparam logic [7:0] FO = pevirq_pkg::OFF_FORCE;
    localparam logic [7:0] MO = pevirq_pkg::OFF_MODE;

    pevirq_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .new_pattern_i(np), .rotation_direction_i(dir), .pattern_error_i(perr),
        .bounce_i(bnc), .rev_count_step_i(step), .rev_count_equal_i(eq),
        .irq_o(irq_o), .err_irq_o(err_irq_o));

    pevirq_src src (.clk_i(clk_i), .new_pattern_o(np), .rotation_direction_o(dir),
        .pattern_error_o(perr), .bounce_o(bnc), .rev_count_step_o(step),
        .rev_count_equal_o(eq));

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // run is a few hundred cycles; the ceiling leaves wide margin
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // a strobe is lowered and one edge passes, so no signal is set twice per step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    // read data are sampled at the edge that ends their single valid cycle
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        chk(rdata_o, exp);
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic irqchk(input logic ei, input logic ee);
        chk({30'h0000_0000, irq_o, err_irq_o}, {30'h0000_0000, ei, ee});
    endtask : irqchk

    initial
    begin
        {resetn_i, wr_i, rd_i, addr_i, wdata_i} = 43'h0;
        err_total = 0;
        checks_done = 0;
        cycles = 0;
        ev_v = '{6'h20, 6'h30, 6'h08, 6'h04, 6'h03, 6'h11, 6'h02, 6'h30};
        ev_e = '{32'h8000_0000, 32'hC000_0000, 32'h2000_0000, 32'h1000_0000,
            32'h0800_0000, 32'h0000_0000, 32'h0000_0000, 32'h8000_0000};
        tick(2);
        resetn_i <= 1'b1;
        tick(1);
        for (i = 0; i < 5; i++)
            rdchk(8'(4 * i), 32'h0000_0000);
        rdchk(pevirq_pkg::OFF_CTRL, 32'h0000_0001);
        rdchk(8'h18, 32'h0000_0000);
        wr(EN, 32'hFFFF_FFFF);
        rdchk(EN, 32'hF800_0000);
        wr(EE, 32'h07FF_FFFF);
        rdchk(EE, 32'h0000_0000);
        for (i = 0; i < 4; i++)
        begin
            wr(MO, {i[1:0], 30'h3FFF_FFFF});
            rdchk(MO, {i[1:0], 30'h0000_0000});
        end
        wr(MO, 32'h0000_0000);
        wr(EN, 32'h0000_0000);
        // each event, then a read, a zero write, a read, a one write and a read
        for (i = 0; i < 8; i++)
        begin
            src.fire(ev_v[i]);
            rdchk(FL, ev_e[i]);
            wr(FL, 32'h0000_0000);
            rdchk(FL, ev_e[i]);
            wr(FL, 32'hFFFF_FFFF);
            rdchk(FL, 32'h0000_0000);
        end
        wr(EN, 32'h2000_0000);
        wr(EE, 32'h1000_0000);
        src.fire(6'h08);
        tick(2);
        irqchk(1'b1, 1'b0);
        wr(FL, 32'h2000_0000);
        tick(1);
        irqchk(1'b0, 1'b0);
        src.fire(6'h04);
        tick(2);
        irqchk(1'b0, 1'b1);
        src.fire(6'h20);
        tick(2);
        irqchk(1'b0, 1'b1);
        wr(FL, 32'hF800_0000);
        // protection is set out of reset, so this write must not force
        wr(FO, 32'hF800_0000);
        rdchk(FL, 32'h0000_0000);
        wr(pevirq_pkg::OFF_CTRL, 32'h0000_0000);
        wr(FO, 32'h0000_0000);
        rdchk(FL, 32'h0000_0000);
        wr(FO, 32'h2000_0000);
        rdchk(FL, 32'h2000_0000);
        rdchk(FO, 32'h0000_0000);
        irqchk(1'b1, 1'b0);
        wr(FO, 32'hF800_0000);
        rdchk(FL, 32'hF800_0000);
        wr(FL, 32'hF800_0000);
        wr(MO, 32'h4000_0000);
        src.fire(6'h08);
        tick(1);
        irqchk(1'b1, 1'b0);
        tick(1);
        irqchk(1'b0, 1'b0);
        // pulse-notify pulses once per event and keeps the flag
        wr(MO, 32'h8000_0000);
        src.fire(6'h08);
        tick(1);
        irqchk(1'b1, 1'b0);
        tick(1);
        irqchk(1'b0, 1'b0);
        rdchk(FL, 32'h2000_0000);
        // single-pulse stays quiet while an enabled flag is pending
        wr(MO, 32'hC000_0000);
        src.fire(6'h08);
        tick(1);
        irqchk(1'b0, 1'b0);
        wr(FL, 32'h2000_0000);
        src.fire(6'h08);
        tick(1);
        irqchk(1'b1, 1'b0);
        tick(1);
        irqchk(1'b0, 1'b0);
        // reset in mid-run must drop every setting made above
        resetn_i <= 1'b0;
        tick(1);
        resetn_i <= 1'b1;
        tick(1);
        irqchk(1'b0, 1'b0);
        for (i = 0; i < 5; i++)
            rdchk(8'(4 * i), 32'h0000_0000);
        rdchk(pevirq_pkg::OFF_CTRL, 32'h0000_0001);
        stop_test();
    end
endmodule : tb_pevirq_regs
